// >>> core/hdlirq_pkg.sv
// Constants and types shared by the data link interrupt enable block
package hdlirq_pkg;

  // Wishbone register map, byte addresses
  localparam int unsigned ADR_W = 4;
  localparam logic [3:0] ENABLE_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;

  // Event and enable field layout, shared by both registers
  localparam int unsigned EVT_N = 7;
  localparam int unsigned TX_BEGIN_BIT = 6;
  localparam int unsigned RX_BEGIN_BIT = 5;
  localparam int unsigned TX_DONE_BIT = 4;
  localparam int unsigned RX_DONE_BIT = 3;
  localparam int unsigned FCS_ERR_BIT = 2;
  localparam int unsigned ABORT_BIT = 1;
  localparam int unsigned IDLE_BIT = 0;
  localparam int unsigned RSVD_BIT = 7;

  // Reset values
  localparam logic [6:0] ENABLE_RESET = 7'h00;
  localparam logic [6:0] STATUS_RESET = 7'h00;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // Line patterns
  localparam logic [7:0] IDLE_FLAG_OCTET = 8'h7E;
  localparam logic [2:0] ABORT_RUN_LEN = 3'h7;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } hdlirq_bus_state_t;

endpackage

// >>> core/hdlirq_dl_if.sv
// Carrier between the core and the receive data link pattern detector
`timescale 1ns/1ps
interface hdlirq_dl_if;
  logic bit_val;
  logic bit_valid;
  logic abort_seen;
  logic idle_seen;
  modport det (input bit_val, input bit_valid, output abort_seen, output idle_seen);
  modport core (output bit_val, output bit_valid, input abort_seen, input idle_seen);
endinterface

// >>> core/hdlirq_dl_detect.sv
// Abort run and idle flag detector on the incoming data link bit stream
`timescale 1ns/1ps
module hdlirq_dl_detect (
  input wire logic clk_i,
  input wire logic reset_n_i,
  hdlirq_dl_if.det dl
);

  logic [7:0] shift_q;
  logic [2:0] run_q;
  logic abort_q;
  logic idle_q;
  logic [7:0] octet;

  assign octet = {shift_q[6:0], dl.bit_val};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_q <= 8'h00;
    end else if (dl.bit_valid) begin
      shift_q <= octet;
    end
  end

  // Run saturates so a long string of ones reports one abort only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_q <= 3'h0;
    end else if (dl.bit_valid) begin
      if (!dl.bit_val) begin
        run_q <= 3'h0;
      end else if (run_q != hdlirq_pkg::ABORT_RUN_LEN) begin
        run_q <= run_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      abort_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      abort_q <= dl.bit_valid && dl.bit_val && (run_q == 3'(hdlirq_pkg::ABORT_RUN_LEN - 3'h1));
      idle_q <= dl.bit_valid && (octet == hdlirq_pkg::IDLE_FLAG_OCTET);
    end
  end

  assign dl.abort_seen = abort_q;
  assign dl.idle_seen = idle_q;

endmodule // hdlirq_dl_detect

// >>> core/hdlirq_core.sv
// Data link interrupt enable, event status and Wishbone register slave
`timescale 1ns/1ps
module hdlirq_core (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_msg_begin_event_i,
  input wire logic rx_msg_begin_event_i,
  input wire logic tx_msg_done_event_i,
  input wire logic rx_msg_done_event_i,
  input wire logic rx_buffer_full_i,
  input wire logic frame_check_error_event_i,
  input wire logic rx_dl_bit_i,
  input wire logic rx_dl_valid_i,
  output logic irq_o
);

  function automatic logic hdlirq_hit(input logic [3:0] adr, input logic [3:0] target);
    hdlirq_hit = (adr[3:2] == target[3:2]);
  endfunction

  hdlirq_pkg::hdlirq_bus_state_t state_q;
  hdlirq_pkg::hdlirq_bus_state_t state_d;
  logic [6:0] enable_q;
  logic [6:0] status_q;
  logic [6:0] status_d;
  logic [6:0] evt_vec;
  logic [6:0] rd_clear;
  logic [6:0] wr_clear;
  logic [31:0] rdata_q;
  logic take;
  logic commit;
  logic wr_enable;
  logic wr_status;
  logic rd_status;

  hdlirq_dl_if dl ();

  assign dl.bit_val = rx_dl_bit_i;
  assign dl.bit_valid = rx_dl_valid_i;

  hdlirq_dl_detect u_detect (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .dl(dl)
  );

  // Event vector in register bit order
  always_comb begin
    evt_vec = 7'h00;
    evt_vec[hdlirq_pkg::TX_BEGIN_BIT] = tx_msg_begin_event_i;
    evt_vec[hdlirq_pkg::RX_BEGIN_BIT] = rx_msg_begin_event_i;
    evt_vec[hdlirq_pkg::TX_DONE_BIT] = tx_msg_done_event_i;
    evt_vec[hdlirq_pkg::RX_DONE_BIT] = rx_msg_done_event_i || rx_buffer_full_i;
    evt_vec[hdlirq_pkg::FCS_ERR_BIT] = frame_check_error_event_i;
    evt_vec[hdlirq_pkg::ABORT_BIT] = dl.abort_seen;
    evt_vec[hdlirq_pkg::IDLE_BIT] = dl.idle_seen;
  end

  // Bus slave: take in IDLE, answer one cycle later, commit at the ack edge
  assign take = (state_q == hdlirq_pkg::BUS_IDLE) && wb_cyc_i && wb_stb_i;
  assign commit = (state_q == hdlirq_pkg::BUS_ACK) && wb_cyc_i && wb_stb_i;
  assign wr_enable = commit && wb_we_i && wb_sel_i[0] && hdlirq_hit(wb_adr_i, hdlirq_pkg::ENABLE_ADDR);
  assign wr_status = commit && wb_we_i && wb_sel_i[0] && hdlirq_hit(wb_adr_i, hdlirq_pkg::STATUS_ADDR);
  assign rd_status = commit && !wb_we_i && hdlirq_hit(wb_adr_i, hdlirq_pkg::STATUS_ADDR);

  always_comb begin
    unique case (state_q)
      hdlirq_pkg::BUS_IDLE: begin
        state_d = take ? hdlirq_pkg::BUS_ACK : hdlirq_pkg::BUS_IDLE;
      end
      hdlirq_pkg::BUS_ACK: begin
        state_d = hdlirq_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= hdlirq_pkg::BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign wb_ack_o = (state_q == hdlirq_pkg::BUS_ACK);

  // Read data is captured when the request is taken; unmapped reads give zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= hdlirq_pkg::RDATA_RESET;
    end else if (take) begin
      rdata_q <= hdlirq_pkg::RDATA_RESET;
      if (hdlirq_hit(wb_adr_i, hdlirq_pkg::ENABLE_ADDR)) begin
        rdata_q[6:0] <= enable_q;
      end else if (hdlirq_hit(wb_adr_i, hdlirq_pkg::STATUS_ADDR)) begin
        rdata_q[6:0] <= status_q;
      end
    end
  end

  assign wb_dat_o = rdata_q;

  // Reserved bit 7 has no storage, so writes to it vanish
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_q <= hdlirq_pkg::ENABLE_RESET;
    end else if (wr_enable) begin
      enable_q <= wb_dat_i[6:0];
    end
  end

  // Only the bits the host actually saw are cleared by the read, so an
  // event landing between capture and ack is kept for the next read
  assign rd_clear = rd_status ? rdata_q[6:0] : 7'h00;
  assign wr_clear = wr_status ? wb_dat_i[6:0] : 7'h00;

  // Set wins over either clear
  generate
    for (genvar b = 0; b < hdlirq_pkg::EVT_N; b++) begin : g_status
      assign status_d[b] = evt_vec[b] || (status_q[b] && !rd_clear[b] && !wr_clear[b]);
    end
  endgenerate

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_q <= hdlirq_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  assign irq_o = |(status_q & enable_q);

  // ---------------------------------------------------------------------
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_take;
    (state_q == hdlirq_pkg::BUS_IDLE) && wb_cyc_i && wb_stb_i;
  endsequence

  sequence s_status_read;
    wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i && hdlirq_hit(wb_adr_i, hdlirq_pkg::STATUS_ADDR);
  endsequence

  sequence s_enable_write;
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
      && hdlirq_hit(wb_adr_i, hdlirq_pkg::ENABLE_ADDR);
  endsequence

  property p_gate(int b);
    evt_vec[b] && enable_q[b] && !wr_enable |=> irq_o && status_q[b];
  endproperty

  property p_blocked(int b);
    evt_vec[b] && !enable_q[b] && !wr_enable && ((status_q & enable_q) == 7'h00)
      && !(|(evt_vec & enable_q)) |=> !irq_o;
  endproperty

  a_tx_begin_gate: assert property (p_gate(6))
    else $error("tx start event did not raise irq");
  a_tx_begin_block: assert property (p_blocked(6))
    else $error("tx start event raised irq while disabled");
  a_rx_begin_gate: assert property (p_gate(5))
    else $error("rx start event did not raise irq");
  a_tx_done_gate: assert property (p_gate(4))
    else $error("tx done event did not raise irq");
  a_rx_done_gate: assert property (p_gate(3))
    else $error("rx done event did not raise irq");
  a_fcs_err_gate: assert property (p_gate(2))
    else $error("fcs error event did not raise irq");
  a_abort_gate: assert property (p_gate(1))
    else $error("abort event did not raise irq");
  a_idle_gate: assert property (p_gate(0))
    else $error("idle flag event did not raise irq");

  // Seven ones in a row on valid bits must report an abort one cycle on
  a_abort_seven_ones: assert property (
    (rx_dl_valid_i && !rx_dl_bit_i) ##1 (rx_dl_valid_i && rx_dl_bit_i) [*7] |=> dl.abort_seen)
    else $error("abort run of seven ones not reported");

  a_idle_flag_octet: assert property (
    rx_dl_valid_i && !rx_dl_bit_i ##1 (rx_dl_valid_i && rx_dl_bit_i) [*6]
      ##1 (rx_dl_valid_i && !rx_dl_bit_i) |=> dl.idle_seen)
    else $error("idle flag octet not reported");

  a_status_read_clr: assert property (
    s_status_read ##0 (evt_vec == 7'h00) |=> ((status_q & $past(rdata_q[6:0])) == 7'h00))
    else $error("status bits not cleared by read");

  a_status_set_wins: assert property (
    s_status_read ##0 (evt_vec != 7'h00) |=> ((status_q & $past(evt_vec)) == $past(evt_vec)))
    else $error("event lost during status read");

  a_status_hold: assert property (
    !wb_ack_o && (evt_vec == 7'h00) |=> status_q == $past(status_q))
    else $error("status changed without event or access");

  a_buf_full_done: assert property (
    rx_buffer_full_i |=> status_q[hdlirq_pkg::RX_DONE_BIT])
    else $error("buffer full did not set rx done status");

  a_irq_quiet: assert property (
    ((status_q & enable_q) == 7'h00) |-> !irq_o)
    else $error("irq high with no enabled status");

  a_reserved_zero: assert property (
    wb_ack_o |-> (wb_dat_o[31:hdlirq_pkg::RSVD_BIT] == 25'h0000000))
    else $error("reserved read bits not zero");

  a_enable_write: assert property (
    s_enable_write |=> enable_q == $past(wb_dat_i[6:0]))
    else $error("enable write not stored");

  a_ack_one_cycle: assert property (
    s_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after take");

  a_enable_read_back: assert property (
    s_take ##0 (!wb_we_i && hdlirq_hit(wb_adr_i, hdlirq_pkg::ENABLE_ADDR)) ##0 !wr_enable
      |=> wb_dat_o[6:0] == $past(enable_q))
    else $error("enable read back wrong");

  property p_set(int b);
    evt_vec[b] |=> status_q[b];
  endproperty

  a_tx_begin_set: assert property (p_set(6))
    else $error("tx start event did not set status");
  a_rx_begin_set: assert property (p_set(5))
    else $error("rx start event did not set status");
  a_tx_done_set: assert property (p_set(4))
    else $error("tx done event did not set status");
  a_rx_done_set: assert property (p_set(3))
    else $error("rx done event did not set status");
  a_fcs_err_set: assert property (p_set(2))
    else $error("fcs error event did not set status");
  a_abort_set: assert property (p_set(1))
    else $error("abort event did not set status");
  a_idle_set: assert property (p_set(0))
    else $error("idle flag event did not set status");

  a_rx_begin_block: assert property (p_blocked(5))
    else $error("rx start event raised irq while disabled");
  a_tx_done_block: assert property (p_blocked(4))
    else $error("tx done event raised irq while disabled");
  a_rx_done_block: assert property (p_blocked(3))
    else $error("rx done event raised irq while disabled");
  a_fcs_err_block: assert property (p_blocked(2))
    else $error("fcs error event raised irq while disabled");
  a_abort_block: assert property (p_blocked(1))
    else $error("abort event raised irq while disabled");
  a_idle_block: assert property (p_blocked(0))
    else $error("idle flag event raised irq while disabled");

  a_ack_needs_req: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");

  a_ack_no_back: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

  a_ack_from_idle: assert property (
    wb_ack_o |-> $past(state_q) == hdlirq_pkg::BUS_IDLE)
    else $error("ack not preceded by idle state");

  // Read data is a snapshot and must not move between takes
  a_rdata_hold: assert property (
    !((state_q == hdlirq_pkg::BUS_IDLE) && wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data changed without a take");

  a_status_read_data: assert property (
    s_take ##0 (!wb_we_i && hdlirq_hit(wb_adr_i, hdlirq_pkg::STATUS_ADDR)) |=> wb_dat_o[6:0] == $past(status_q))
    else $error("status read data wrong");

  a_unmapped_zero: assert property (
    s_take ##0 (!hdlirq_hit(wb_adr_i, hdlirq_pkg::ENABLE_ADDR) && !hdlirq_hit(wb_adr_i, hdlirq_pkg::STATUS_ADDR))
      |=> wb_dat_o == hdlirq_pkg::RDATA_RESET)
    else $error("unmapped read not zero");

  a_sel_gate_write: assert property (
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0] |=> $stable(enable_q))
    else $error("write without byte lane changed enable");

  a_enable_hold: assert property (
    !wr_enable |=> $stable(enable_q))
    else $error("enable changed without a write");

  a_w1c_clear: assert property (
    wr_status && (evt_vec == 7'h00) |=> ((status_q & $past(wb_dat_i[6:0])) == 7'h00))
    else $error("write one did not clear status");

  a_w1c_set_wins: assert property (
    wr_status && (evt_vec != 7'h00) |=> ((status_q & $past(evt_vec)) == $past(evt_vec)))
    else $error("event lost during status write");

  a_enable_read_keep: assert property (
    wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i && hdlirq_hit(wb_adr_i, hdlirq_pkg::ENABLE_ADDR)
      |=> ((status_q & $past(status_q)) == $past(status_q)))
    else $error("enable read cleared status");

  a_status_read_keep: assert property (
    s_status_read |=> $stable(enable_q))
    else $error("status read changed enable");

  a_irq_enabled: assert property (
    ((status_q & enable_q) != 7'h00) |-> irq_o)
    else $error("irq low with enabled status");

  a_abort_once: assert property (
    dl.abort_seen |=> !dl.abort_seen)
    else $error("abort reported twice in a row");

  a_idle_single: assert property (
    dl.idle_seen |=> !dl.idle_seen)
    else $error("idle flag reported twice in a row");

  a_valid_low_quiet: assert property (
    !rx_dl_valid_i |=> !dl.abort_seen && !dl.idle_seen)
    else $error("pattern reported on an invalid bit");

  a_buf_full_irq: assert property (
    rx_buffer_full_i && enable_q[hdlirq_pkg::RX_DONE_BIT] && !wr_enable |=> irq_o)
    else $error("buffer full did not raise irq");

endmodule // hdlirq_core

// >>> tb/hdlirq_host.sv
// Host model: Wishbone master that performs single register reads and writes for the bench
`timescale 1ns/1ps
module hdlirq_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [3:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 4'hC;
    sel_o = 4'h0;
    dat_o = 32'hA5A5A5A5;
  end

  // No cycle limit of its own; a lost ack is ended by the bench watchdog
  task automatic access(input logic wr, input logic [3:0] adr, input logic [31:0] wdat,
                        input logic [3:0] sel, output logic [31:0] rdat);
    rdat = 32'hXXXXXXXX;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= wr;
    adr_o <= adr;
    sel_o <= sel;
    dat_o <= wdat;
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    rdat = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released address and data lines carry a changed pattern, not the last value
    adr_o <= ~adr;
    dat_o <= ~wdat;
    sel_o <= 4'h0;
  endtask
endmodule // hdlirq_host

// >>> tb/hdlirq_core_tb_top.sv
// Self-checking testbench for the data link interrupt enable block
`timescale 1ns/1ps
module hdlirq_core_tb_top;
  logic clk_i, reset_n_i, wb_cyc, wb_stb, wb_we, wb_ack, irq, buf_full, dl_bit, dl_valid;
  logic [3:0] wb_adr, wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [6:2] ev;
  int num_errors = 0;
  int check_count = 0;

  hdlirq_core hdlirq_core_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .tx_msg_begin_event_i(ev[6]), .rx_msg_begin_event_i(ev[5]), .tx_msg_done_event_i(ev[4]),
    .rx_msg_done_event_i(ev[3]), .rx_buffer_full_i(buf_full), .frame_check_error_event_i(ev[2]),
    .rx_dl_bit_i(dl_bit), .rx_dl_valid_i(dl_valid), .irq_o(irq));

  hdlirq_host hdlirq_host_inst (.clk_i(clk_i), .ack_i(wb_ack), .dat_i(wb_rdat), .cyc_o(wb_cyc),
    .stb_o(wb_stb), .we_o(wb_we), .adr_o(wb_adr), .sel_o(wb_sel), .dat_o(wb_wdat));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    hdlirq_host_inst.access(1'b1, a, d, s, r);
  endtask

  task automatic rd_check(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] r;
    hdlirq_host_inst.access(1'b0, a, 32'h00000000, 4'hF, r);
    check(r, exp);
  endtask

  task automatic pulse(input logic [6:2] m, input logic bf);
    @(posedge clk_i);
    ev <= m;
    buf_full <= bf;
    @(posedge clk_i);
    ev <= 5'h00;
    buf_full <= 1'b0;
    #1;
  endtask

  task automatic dl_send(input logic [7:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i);
      dl_bit <= v[i];
      dl_valid <= 1'b1;
    end
    @(posedge clk_i);
    dl_valid <= 1'b0;
    dl_bit <= ~v[0];
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic t_reset_reserved();
    rd_check(hdlirq_pkg::ENABLE_ADDR, 32'h00000000);
    rd_check(hdlirq_pkg::STATUS_ADDR, 32'h00000000);
    check({31'h00000000, irq}, 32'h00000000);
    wr(hdlirq_pkg::ENABLE_ADDR, 32'h000000FF, 4'hF);
    rd_check(hdlirq_pkg::ENABLE_ADDR, 32'h0000007F);
    wr(hdlirq_pkg::ENABLE_ADDR, 32'h00000000, 4'hE);
    rd_check(hdlirq_pkg::ENABLE_ADDR, 32'h0000007F);
    rd_check(4'h8, 32'h00000000);
  endtask

  // Each event input source, bits 2 to 6, alone enabled, then the same source masked by all the others
  task automatic t_sources();
    logic [31:0] b;
    for (int i = 2; i <= 6; i++) begin
      b = 32'h00000001 << i;
      wr(hdlirq_pkg::ENABLE_ADDR, b, 4'hF);
      pulse(b[6:2], 1'b0);
      check({31'h00000000, irq}, 32'h00000001);
      rd_check(hdlirq_pkg::STATUS_ADDR, b);
      #1;
      check({31'h00000000, irq}, 32'h00000000);
      rd_check(hdlirq_pkg::STATUS_ADDR, 32'h00000000);
      wr(hdlirq_pkg::ENABLE_ADDR, ~b & 32'h0000007F, 4'hF);
      pulse(b[6:2], 1'b0);
      check({31'h00000000, irq}, 32'h00000000);
      rd_check(hdlirq_pkg::STATUS_ADDR, b);
    end
  endtask

  task automatic t_buffer_clear();
    wr(hdlirq_pkg::ENABLE_ADDR, 32'h00000008, 4'hF);
    pulse(5'h00, 1'b1);
    check({31'h00000000, irq}, 32'h00000001);
    rd_check(hdlirq_pkg::STATUS_ADDR, 32'h00000008);
    pulse(5'h11, 1'b0);
    wr(hdlirq_pkg::STATUS_ADDR, 32'h00000004, 4'hF);
    rd_check(hdlirq_pkg::STATUS_ADDR, 32'h00000040);
  endtask

  // Idle octet ends in a zero, so seven ones after it form one abort run
  task automatic t_line_patterns();
    wr(hdlirq_pkg::ENABLE_ADDR, 32'h00000001, 4'hF);
    dl_send(8'h7E, 8);
    check({31'h00000000, irq}, 32'h00000001);
    rd_check(hdlirq_pkg::STATUS_ADDR, 32'h00000001);
    wr(hdlirq_pkg::ENABLE_ADDR, 32'h00000002, 4'hF);
    dl_send(8'h7F, 7);
    check({31'h00000000, irq}, 32'h00000001);
    rd_check(hdlirq_pkg::STATUS_ADDR, 32'h00000002);
  endtask

  initial begin
    reset_n_i = 1'b0;
    ev = 5'h00;
    buf_full = 1'b0;
    dl_bit = 1'b0;
    dl_valid = 1'b0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset_reserved();
    t_sources();
    t_buffer_clear();
    t_line_patterns();
    stop_test();
  end

  // About 200 cycles are needed; a hundred times that means a hang
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule // hdlirq_core_tb_top
